// file: src/async_dma_pkg.sv
// Purpose: Shared constants for the asynchronous DMA context control block
// Assumes: APB with 12-bit byte addresses and 32-bit data
// Notes: Register addresses, field positions, speed codes and reset values

package async_dma_pkg;

	localparam int NUM_CTX = 4;
	localparam int FIRST_RX_CTX = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Register map, index 0 = tx request, 1 = tx response, 2 = rx request, 3 = rx response
	localparam logic [3:0][11:0] CTX_SET_ADDR = {12'h1e0, 12'h1c0, 12'h1a0, 12'h180};
	localparam logic [3:0][11:0] CTX_CLR_ADDR = {12'h1e4, 12'h1c4, 12'h1a4, 12'h184};
	localparam logic [3:0][11:0] CTX_PTR_ADDR = {12'h1ec, 12'h1cc, 12'h1ac, 12'h18c};
	localparam logic [11:0] IRQ_STATUS_ADDR = 12'h300;
	localparam logic [11:0] IRQ_MASK_ADDR = 12'h304;

	////////////////////////////////////////////////////////////////////////////////
	// Control register fields
	localparam int RUN_BIT = 15;
	localparam int WAKE_BIT = 12;
	localparam int DEAD_BIT = 11;
	localparam int ACTIVE_BIT = 10;
	localparam int SPD_MSB = 7;
	localparam int SPD_LSB = 5;
	localparam int EVT_MSB = 4;
	localparam int PTR_COUNT_MSB = 3;
	localparam int PTR_ADDR_LSB = 4;

	////////////////////////////////////////////////////////////////////////////////
	// Speed codes, all others reserved
	localparam logic [2:0] SPD_100 = 3'h0;
	localparam logic [2:0] SPD_200 = 3'h1;
	localparam logic [2:0] SPD_400 = 3'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [31:0] PTR_RESET = 32'h0000_0000;
	localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

endpackage

// file: src/async_dma_irq.sv
// Purpose: Sticky interrupt status, mask and level interrupt output
// Assumes: Event pulses and write strobes on clk_sys
// Notes: Status bits clear by writing one; a new event wins over the clear

`timescale 1ns/1ns

module async_dma_irq (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Events, low nibble fatal per context, high nibble completion
	input wire logic [7:0] eventIn,
	// Register writes
	input wire logic wrStatus,
	input wire logic wrMask,
	input wire logic [7:0] wdata,
	// Readback and interrupt
	output logic [7:0] status,
	output logic [7:0] mask,
	output logic irq
);

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] mask;
		logic irq;
	} irq_state_t;

	irq_state_t q;
	irq_state_t d;

	always_comb begin
		d = q;
		// Set beats clear so a late event is never lost
		if (wrStatus) begin
			d.status = q.status & ~wdata;
		end
		d.status = d.status | eventIn;
		if (wrMask) begin
			d.mask = wdata;
		end
		d.irq = |(d.status & d.mask);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			q <= '{status: async_dma_pkg::IRQ_STATUS_RESET, mask: async_dma_pkg::IRQ_MASK_RESET, irq: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign status = q.status;
	assign mask = q.mask;
	assign irq = q.irq;

	chk_irq_level: assert property (@(posedge clk_sys) disable iff (!rstn)
		irq == |(status & mask))
		else $error("irq level does not follow masked status");

	chk_irq_set_wins: assert property (@(posedge clk_sys) disable iff (!rstn)
		wrStatus & (eventIn != 8'h00) |=> (status & $past(eventIn)) == $past(eventIn))
		else $error("event lost to a status clear");

endmodule

// file: src/async_dma_context_control.sv
// Purpose: Control, status and command pointer for four asynchronous DMA contexts
// Assumes: APB slave, one wait state; DMA engine strobes are on clk_sys
// Notes: Speed field of transmit contexts reads as zero
// Operation
// - Descriptor processing runs while run bit 15 is set, stops when cleared.
// - Hardware never sets run; only a clear write or reset clears it.
// - Wake bit 12 resumes processing; a descriptor fetch clears it unless software sets it in the same cycle.
// - Fatal error while run is set sets dead bit 11; clearing run clears dead.
// - Active bit 10 is one while descriptors are being processed.
// - Speed codes: 000 100M, 001 200M, 010 400M, rest reserved.
// - Speed field bits 7:5 meaningful only on receive contexts.
// - Event code bits 4:0 hold link acknowledge or internal error code.
// - Control bits 31:16, 14:13 and 9:8 always read zero.
// - Each context has set and clear addresses, clear four bytes higher.
// - Setting run starts fetching at the command pointer's descriptor block.
// - Pointer holds upper 28 address bits; blocks are 16-byte aligned.
// - Descriptor count bits 3:0; zero marks the pointer invalid.
//
// The APB register port was left to the implementer.

`timescale 1ns/1ns

module async_dma_context_control (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic softRst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// DMA engine status, one bit or field per context
	input wire logic [3:0] descFetch,
	input wire logic [3:0] listEnd,
	input wire logic [3:0] fatalErr,
	input wire logic [3:0] evtValid,
	input wire logic [19:0] evtCode,
	input wire logic [11:0] evtSpeed,
	// DMA engine control
	output logic [3:0] ctxRun,
	output logic [3:0] ctxActive,
	output logic [3:0] fetchStart,
	output logic [3:0] fetchResume,
	output logic [127:0] fetchPtr,
	// Interrupt
	output logic irq
);

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [3:0] run;
		logic [3:0] wake;
		logic [3:0] dead;
		logic [3:0] active;
		logic [3:0] startP;
		logic [3:0] resumeP;
		logic [3:0][2:0] spd;
		logic [3:0][4:0] evt;
		logic [3:0][31:0] ptr;
	} dma_state_t;

	dma_state_t q;
	dma_state_t d;

	logic accessCycle;
	logic wrFire;
	logic [3:0] setHit;
	logic [3:0] clrHit;
	logic [3:0] ptrHit;
	logic [3:0] runSet;
	logic [3:0] runClr;
	logic [3:0] wakeSet;
	logic [3:0] countZero;
	logic statusHit;
	logic maskHit;
	logic rdErr;
	logic [31:0] rdWord;
	logic [7:0] irqEvents;
	logic [7:0] irqStatus;
	logic [7:0] irqMask;

	////////////////////////////////////////////////////////////////////////////////
	// Control word as software sees it; unlisted bits stay zero
	function automatic logic [31:0] ctrl_word(input logic run, input logic wake, input logic dead,
		input logic active, input logic [2:0] spd, input logic [4:0] evt);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[async_dma_pkg::RUN_BIT] = run;
		w[async_dma_pkg::WAKE_BIT] = wake;
		w[async_dma_pkg::DEAD_BIT] = dead;
		w[async_dma_pkg::ACTIVE_BIT] = active;
		w[async_dma_pkg::SPD_MSB:async_dma_pkg::SPD_LSB] = spd;
		w[async_dma_pkg::EVT_MSB:0] = evt;
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		d = q;
		d.startP = 4'h0;
		d.resumeP = 4'h0;
		accessCycle = psel & penable;
		// Writes land only at the edge that completes the access
		wrFire = accessCycle & q.pready & pwrite;
		d.pready = accessCycle & !q.pready;
		statusHit = (paddr == async_dma_pkg::IRQ_STATUS_ADDR);
		maskHit = (paddr == async_dma_pkg::IRQ_MASK_ADDR);
		rdErr = !(statusHit | maskHit);
		rdWord = 32'h0000_0000;
		if (statusHit) begin
			rdWord = {24'h00_0000, irqStatus};
		end
		if (maskHit) begin
			rdWord = {24'h00_0000, irqMask};
		end
		for (int i = 0; i < async_dma_pkg::NUM_CTX; i++) begin
			setHit[i] = (paddr == async_dma_pkg::CTX_SET_ADDR[i]);
			clrHit[i] = (paddr == async_dma_pkg::CTX_CLR_ADDR[i]);
			ptrHit[i] = (paddr == async_dma_pkg::CTX_PTR_ADDR[i]);
			if (setHit[i] | clrHit[i]) begin
				rdWord = ctrl_word(q.run[i], q.wake[i], q.dead[i], q.active[i], q.spd[i], q.evt[i]);
				rdErr = 1'b0;
			end
			if (ptrHit[i]) begin
				rdWord = q.ptr[i];
				rdErr = 1'b0;
			end
			// Only ones act; zero bits leave the control bits alone
			runSet[i] = wrFire & setHit[i] & pwdata[async_dma_pkg::RUN_BIT];
			runClr[i] = wrFire & clrHit[i] & pwdata[async_dma_pkg::RUN_BIT];
			wakeSet[i] = wrFire & setHit[i] & pwdata[async_dma_pkg::WAKE_BIT];
			countZero[i] = (q.ptr[i][async_dma_pkg::PTR_COUNT_MSB:0] == 4'h0);

			// Run changes only by software or by reset
			if (softRst | runClr[i]) begin
				d.run[i] = 1'b0;
			end else if (runSet[i]) begin
				d.run[i] = 1'b1;
			end

			// Wake: software set beats the fetch clear
			if (softRst) begin
				d.wake[i] = 1'b0;
			end else if (wakeSet[i]) begin
				d.wake[i] = 1'b1;
			end else if (descFetch[i]) begin
				d.wake[i] = 1'b0;
			end

			// Dead: a fatal error beats a run clear in the same cycle
			if (fatalErr[i] & q.run[i] & !softRst) begin
				d.dead[i] = 1'b1;
			end else if (softRst | runClr[i]) begin
				d.dead[i] = 1'b0;
			end

			// Active tracks descriptor processing
			if (softRst | runClr[i] | !q.run[i] & !runSet[i] | fatalErr[i] & q.run[i]) begin
				d.active[i] = 1'b0;
			end else if (runSet[i] & !q.run[i]) begin
				// Zero count means no valid block, so nothing is fetched
				if (!countZero[i] & !q.dead[i]) begin
					d.active[i] = 1'b1;
					d.startP[i] = 1'b1;
				end
			end else if (q.run[i] & !q.active[i] & !q.dead[i] & q.wake[i]) begin
				d.active[i] = 1'b1;
				d.resumeP[i] = 1'b1;
			end else if (q.active[i] & listEnd[i] & !q.wake[i] & !wakeSet[i]) begin
				// A pending wake keeps the context going past the list end
				d.active[i] = 1'b0;
			end

			// Completion status; transmit contexts keep speed at zero
			if (softRst) begin
				d.evt[i] = 5'h00;
				d.spd[i] = async_dma_pkg::SPD_100;
			end else if (evtValid[i]) begin
				d.evt[i] = evtCode[i*5 +: 5];
				if (i >= async_dma_pkg::FIRST_RX_CTX) begin
					d.spd[i] = evtSpeed[i*3 +: 3];
				end else begin
					d.spd[i] = async_dma_pkg::SPD_100;
				end
			end

			// Pointer is plain read and write, whole word
			if (wrFire & ptrHit[i]) begin
				d.ptr[i] = pwdata;
			end
		end
		d.prdata = (d.pready & !pwrite) ? rdWord : 32'h0000_0000;
		d.pslverr = d.pready & rdErr;
		irqEvents = {evtValid & ~{4{softRst}}, d.dead & ~q.dead};
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
			q.ptr <= {4{async_dma_pkg::PTR_RESET}};
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask
	async_dma_irq i_async_dma_irq (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.eventIn(irqEvents),
		.wrStatus(wrFire & statusHit),
		.wrMask(wrFire & maskHit),
		.wdata(pwdata[7:0]),
		.status(irqStatus),
		.mask(irqMask),
		.irq(irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign ctxRun = q.run;
	assign ctxActive = q.active;
	assign fetchStart = q.startP;
	assign fetchResume = q.resumeP;
	// Engine addresses the block on 16-byte bounds; low nibble is the count
	assign fetchPtr = q.ptr;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_apb_wait: assert property (@(posedge clk_sys) disable iff (!rstn)
		psel & penable & !pready |=> pready)
		else $error("apb access not answered after one wait state");

	chk_apb_unmapped: assert property (@(posedge clk_sys) disable iff (!rstn)
		pready |-> pslverr == rdErr)
		else $error("pslverr does not match address decode");

	chk_apb_ready_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
		pready |=> !pready)
		else $error("pready held longer than one cycle");

	genvar g;
	generate
		for (g = 0; g < async_dma_pkg::NUM_CTX; g++) begin : ctxChk
			chk_run_set_write: assert property (@(posedge clk_sys) disable iff (!rstn)
				runSet[g] & !softRst |=> ctxRun[g])
				else $error("run not set by set write");

			chk_run_never_self: assert property (@(posedge clk_sys) disable iff (!rstn)
				$rose(ctxRun[g]) |-> $past(runSet[g]))
				else $error("run rose without software set");

			chk_run_clear_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
				runClr[g] |=> !ctxRun[g] && !ctxActive[g] && (!q.dead[g] || $past(fatalErr[g])))
				else $error("clearing run did not stop context");

			chk_wake_fetch_clr: assert property (@(posedge clk_sys) disable iff (!rstn)
				descFetch[g] & !wakeSet[g] |=> !q.wake[g])
				else $error("wake not cleared by descriptor fetch");

			chk_wake_set_wins: assert property (@(posedge clk_sys) disable iff (!rstn)
				wakeSet[g] & !softRst |=> q.wake[g])
				else $error("wake set lost");

			chk_dead_fatal: assert property (@(posedge clk_sys) disable iff (!rstn)
				fatalErr[g] & ctxRun[g] & !softRst |=> q.dead[g] && !ctxActive[g])
				else $error("fatal error did not set dead");

			chk_active_start: assert property (@(posedge clk_sys) disable iff (!rstn)
				runSet[g] & !ctxRun[g] & !countZero[g] & !q.dead[g] & !softRst
				|=> fetchStart[g] && ctxActive[g] ##1 !fetchStart[g])
				else $error("run set did not start fetch");

			chk_zero_count: assert property (@(posedge clk_sys) disable iff (!rstn)
				runSet[g] & !ctxRun[g] & countZero[g] |=> !fetchStart[g] && !ctxActive[g])
				else $error("fetch started on invalid pointer");

			chk_active_needs_run: assert property (@(posedge clk_sys) disable iff (!rstn)
				ctxActive[g] |-> ctxRun[g] && !q.dead[g])
				else $error("active without run or while dead");

			chk_event_code: assert property (@(posedge clk_sys) disable iff (!rstn)
				evtValid[g] & !softRst |=> q.evt[g] == $past(evtCode[g*5 +: 5]))
				else $error("event code not captured");

			chk_run_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
				ctxRun[g] & !runClr[g] & !softRst |=> ctxRun[g])
				else $error("run dropped without clear or reset");

			chk_wake_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
				q.wake[g] & !descFetch[g] & !softRst |=> q.wake[g])
				else $error("wake dropped without a fetch");

			chk_resume_wake: assert property (@(posedge clk_sys) disable iff (!rstn)
				ctxRun[g] & !ctxActive[g] & !q.dead[g] & q.wake[g] & !softRst & !runClr[g] & !fatalErr[g]
				|=> fetchResume[g] && ctxActive[g])
				else $error("wake did not resume processing");

			chk_list_end: assert property (@(posedge clk_sys) disable iff (!rstn)
				ctxActive[g] & listEnd[g] & !q.wake[g] & !wakeSet[g] |=> !ctxActive[g])
				else $error("context still active after list end");

			chk_start_needs_set: assert property (@(posedge clk_sys) disable iff (!rstn)
				fetchStart[g] |-> $past(runSet[g]))
				else $error("fetch start without run set");

			chk_ptr_write: assert property (@(posedge clk_sys) disable iff (!rstn)
				wrFire & ptrHit[g] |=> fetchPtr[g*32 +: 32] == $past(pwdata))
				else $error("command pointer write lost");

			chk_dead_irq: assert property (@(posedge clk_sys) disable iff (!rstn)
				$rose(q.dead[g]) |-> irqStatus[g])
				else $error("dead rise did not flag interrupt status");

			if (g < async_dma_pkg::FIRST_RX_CTX) begin : txChk
				chk_tx_speed_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
					q.spd[g] == async_dma_pkg::SPD_100)
					else $error("transmit speed field not zero");
			end else begin : rxChk
				chk_rx_speed: assert property (@(posedge clk_sys) disable iff (!rstn)
					evtValid[g] & !softRst |=> q.spd[g] == $past(evtSpeed[g*3 +: 3]))
					else $error("receive speed not captured");
			end
		end
	endgenerate

	chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
		pready & !pslverr & ((paddr & 12'h01b) == 12'h000) & (paddr >= 12'h180) & (paddr < 12'h200)
		|-> (prdata & 32'hffff_6300) == 32'h0000_0000)
		else $error("reserved control bits read nonzero");

endmodule

// file: verif/dma_engine_model.sv
// Purpose: Far-side model of the descriptor engine strobes
// Assumes: Bench commands end, fatal and completion strobes
// Notes: Event fields toggle when not valid, so stale values never pass

`timescale 1ns/1ns

module dma_engine_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// From the block
	input wire logic [3:0] fetchStart,
	input wire logic [3:0] fetchResume,
	// Bench commands
	input wire logic [3:0] doEnd,
	input wire logic [3:0] doFatal,
	input wire logic [3:0] doEvt,
	input wire logic [19:0] codeIn,
	input wire logic [11:0] spdIn,
	// To the block
	output logic [3:0] descFetch,
	output logic [3:0] listEnd,
	output logic [3:0] fatalErr,
	output logic [3:0] evtValid,
	output logic [19:0] evtCode,
	output logic [11:0] evtSpeed
);
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			descFetch <= 4'h0;
			listEnd <= 4'h0;
			fatalErr <= 4'h0;
			evtValid <= 4'h0;
			evtCode <= 20'h0;
			evtSpeed <= 12'h0;
		end else begin
			// One fetch strobe a cycle after each start or resume
			descFetch <= fetchStart | fetchResume;
			listEnd <= doEnd;
			fatalErr <= doFatal;
			evtValid <= doEvt;
			evtCode <= (|doEvt) ? codeIn : ~evtCode;
			evtSpeed <= (|doEvt) ? spdIn : ~evtSpeed;
		end
	end
endmodule

// file: verif/async_dma_context_control_tb.sv
// Purpose: Self-checking bench for the DMA context control block
// Assumes: APB access phase waits on pready, unbounded
// Notes: Context 0 pointer has count 0 so its run never fetches

`timescale 1ns/1ns

module async_dma_context_control_tb;
	logic clk_sys = 0, rstn = 0, softRst = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rerr, irq;
	logic [3:0] descFetch, listEnd, fatalErr, evtValid, ctxRun, ctxActive, fetchStart, fetchResume;
	logic [3:0] doEnd = 4'h0, doFatal = 4'h0, doEvt = 4'h0;
	logic [19:0] evtCode, codeIn = 20'h0;
	logic [11:0] evtSpeed, spdIn = 12'h0;
	logic [127:0] fetchPtr;
	logic [2:0] spds [3] = '{async_dma_pkg::SPD_100, async_dma_pkg::SPD_200, async_dma_pkg::SPD_400};
	int failures = 0, num_checks = 0, nStart = 0, nRes = 0;

	async_dma_context_control i_async_dma_context_control (.clk_sys(clk_sys), .rstn(rstn),
		.softRst(softRst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.descFetch(descFetch), .listEnd(listEnd), .fatalErr(fatalErr), .evtValid(evtValid),
		.evtCode(evtCode), .evtSpeed(evtSpeed), .ctxRun(ctxRun), .ctxActive(ctxActive),
		.fetchStart(fetchStart), .fetchResume(fetchResume), .fetchPtr(fetchPtr), .irq(irq));
	dma_engine_model i_dma_engine_model (.clk_sys(clk_sys), .rstn(rstn), .fetchStart(fetchStart),
		.fetchResume(fetchResume), .doEnd(doEnd), .doFatal(doFatal), .doEvt(doEvt),
		.codeIn(codeIn), .spdIn(spdIn), .descFetch(descFetch), .listEnd(listEnd),
		.fatalErr(fatalErr), .evtValid(evtValid), .evtCode(evtCode), .evtSpeed(evtSpeed));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		nStart += $countones(fetchStart);
		nRes += $countones(fetchResume);
	end

	task automatic close_out();
		if (failures == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chkWord(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("Error %0t word got %h expected %h", $time, g, e);
		end
	endtask
	task automatic chkBit(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("Error %0t bit got %b expected %b", $time, g, e);
		end
	endtask
	// Holds the request until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Only the watchdog ends a hung access
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chkWord(rdat, e);
	endtask
	task automatic strobe(input logic [3:0] e, input logic [3:0] f);
		@(posedge clk_sys);
		doEnd <= e;
		doFatal <= f;
		@(posedge clk_sys);
		doEnd <= 4'h0;
		doFatal <= 4'h0;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic ev(input int c, input logic [4:0] code, input logic [2:0] sp);
		@(posedge clk_sys);
		codeIn[5*c+:5] <= code;
		spdIn[3*c+:3] <= sp;
		doEvt[c] <= 1'b1;
		@(posedge clk_sys);
		doEvt <= 4'h0;
		repeat (3) @(posedge clk_sys);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 4; i++) begin
			rd(async_dma_pkg::CTX_SET_ADDR[i], 32'h0);
			rd(async_dma_pkg::CTX_PTR_ADDR[i], async_dma_pkg::PTR_RESET);
			wr(async_dma_pkg::CTX_PTR_ADDR[i], {24'h000123, 4'(i), 4'(i)});
			rd(async_dma_pkg::CTX_PTR_ADDR[i], {24'h000123, 4'(i), 4'(i)});
		end
		apb(1'b0, 12'h0f0, 32'h0);
		chkBit(rerr, 1'b1);
		chkWord(rdat, 32'h0);
		// Zero count: run sticks but nothing starts
		wr(async_dma_pkg::CTX_SET_ADDR[0], 32'h0000_8000);
		rd(async_dma_pkg::CTX_SET_ADDR[0], 32'h0000_8000);
		chkWord(32'(nStart), 32'h0);
		wr(async_dma_pkg::CTX_SET_ADDR[1], 32'h0000_8000);
		rd(async_dma_pkg::CTX_CLR_ADDR[1], 32'h0000_8400);
		chkBit(ctxActive[1], 1'b1);
		chkWord(32'(nStart), 32'h1);
		chkWord(fetchPtr[63:32], 32'h0001_2311);
		wr(async_dma_pkg::CTX_SET_ADDR[2], 32'hffff_6f00);
		rd(async_dma_pkg::CTX_SET_ADDR[2], 32'h0);
		strobe(4'h2, 4'h0);
		rd(async_dma_pkg::CTX_SET_ADDR[1], 32'h0000_8000);
		wr(async_dma_pkg::CTX_SET_ADDR[1], 32'h0000_1000);
		repeat (4) @(posedge clk_sys);
		rd(async_dma_pkg::CTX_SET_ADDR[1], 32'h0000_8400);
		chkWord(32'(nRes), 32'h1);
		for (int i = 0; i < 3; i++) begin
			ev(3, 5'h11, spds[i]);
			rd(async_dma_pkg::CTX_SET_ADDR[3], {24'h0, spds[i], 5'h11});
		end
		ev(1, 5'h0d, async_dma_pkg::SPD_200);
		rd(async_dma_pkg::CTX_SET_ADDR[1], 32'h0000_840d);
		wr(async_dma_pkg::IRQ_STATUS_ADDR, 32'h0000_00ff);
		rd(async_dma_pkg::IRQ_STATUS_ADDR, 32'h0);
		strobe(4'h0, 4'h2);
		rd(async_dma_pkg::CTX_SET_ADDR[1], 32'h0000_880d);
		chkBit(ctxActive[1], 1'b0);
		rd(async_dma_pkg::IRQ_STATUS_ADDR, 32'h0000_0002);
		chkBit(irq, 1'b0);
		wr(async_dma_pkg::IRQ_MASK_ADDR, 32'h0000_0002);
		repeat (2) @(posedge clk_sys);
		chkBit(irq, 1'b1);
		wr(async_dma_pkg::IRQ_STATUS_ADDR, 32'h0000_0002);
		repeat (2) @(posedge clk_sys);
		chkBit(irq, 1'b0);
		wr(async_dma_pkg::CTX_CLR_ADDR[0], 32'h0);
		rd(async_dma_pkg::CTX_SET_ADDR[0], 32'h0000_8000);
		wr(async_dma_pkg::CTX_CLR_ADDR[1], 32'h0000_8000);
		rd(async_dma_pkg::CTX_SET_ADDR[1], 32'h0000_000d);
		chkBit(ctxRun[1], 1'b0);
		// Fatal with run clear must not mark dead
		strobe(4'h0, 4'h2);
		rd(async_dma_pkg::CTX_SET_ADDR[1], 32'h0000_000d);
		@(posedge clk_sys);
		softRst <= 1'b1;
		@(posedge clk_sys);
		softRst <= 1'b0;
		@(posedge clk_sys);
		rd(async_dma_pkg::CTX_SET_ADDR[0], 32'h0);
		chkWord({28'h0, ctxRun}, 32'h0);
		close_out();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		close_out();
	end
endmodule
